//--- diso_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DISO_CONSTS_SVH
`define DISO_CONSTS_SVH

`define DISO_REG_CTRL        3'h0
`define DISO_REG_WCNT        3'h1
`define DISO_REG_BAR         3'h2
`define DISO_REG_STAT        3'h3
`define DISO_REG_MASK        3'h4
`define DISO_REG_ERRINFO     3'h5

`define DISO_CTRL_GO         0
`define DISO_CTRL_MASTER     1
`define DISO_CTRL_CYCLE      2
`define DISO_STAT_DONE       0
`define DISO_STAT_NXM        1
`define DISO_STAT_BRELEASE   2

`define DISO_RST_WORD        16'h0000
`define DISO_RST_ADDR        18'h00000
`define DISO_RST_EVT         3'h0

`define DISO_CLK_PERIOD_NS   5
`define DISO_TMO_SHORT_US    12
`define DISO_TMO_MID_US      33
`define DISO_TMO_LONG_US     45
`define DISO_BRT_US          4
`define DISO_TMO_SHORT_CYC   ((`DISO_TMO_SHORT_US * 1000) / `DISO_CLK_PERIOD_NS)
`define DISO_TMO_MID_CYC     ((`DISO_TMO_MID_US * 1000) / `DISO_CLK_PERIOD_NS)
`define DISO_TMO_LONG_CYC    ((`DISO_TMO_LONG_US * 1000) / `DISO_CLK_PERIOD_NS)
`define DISO_BRT_CYC         ((`DISO_BRT_US * 1000) / `DISO_CLK_PERIOD_NS)

`endif

//--- diso_pkg.sv
// Types shared by the strap-option DMA block
package diso_pkg;

	typedef enum logic [1:0] {
		DISO_BUSY_HIGH,
		DISO_BUSY_LOW,
		DISO_BUSY_LEGACY_TIMED
	} diso_busy_e;

	typedef enum logic [1:0] {
		DISO_TMO_SHORT,
		DISO_TMO_MID,
		DISO_TMO_LONG
	} diso_tmo_e;

	typedef enum logic [2:0] {
		DISO_IDLE,
		DISO_REQ,
		DISO_XFER,
		DISO_GAP,
		DISO_RELEASE
	} diso_state_e;

	typedef logic [15:0] diso_word_t;

endpackage

//--- diso_sync3.sv
// Three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
module diso_sync3 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] syncOut
);
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic s1_r;
		logic s2_r;
		logic s3_r;
		logic q_r;
		// First stage feeds only the second
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				s1_r <= 1'b0;
				s2_r <= 1'b0;
				s3_r <= 1'b0;
				q_r  <= 1'b0;
			end else begin
				s1_r <= pinIn[i];
				s2_r <= s1_r;
				s3_r <= s2_r;
				if (s2_r == s3_r) begin
					q_r <= s3_r;
				end
			end
		end
		assign syncOut[i] = q_r;
	end
endmodule

//--- diso_strap_dma.sv
// DMA master engine with strap-selected busy, address, register and burst options
`timescale 1ns/1ps
`include "diso_consts.svh"

// What this block does
// [R1] Busy output: high, low or legacy timed
// [R2] Linked or looped pairs must choose low busy
// [R3] Host bus moves whole words only
// [R4] User device drives the byte select bit
// [R5] Suppress strap forces address bit zero
// [R6] Address register bit zero shows far ready; the code reads zero there while the suppress strap is set
// [R7] Legacy strap hides error info register
// [R8] Software should keep error register visible
// [R9] Burst sizes: one, two or unlimited words
// [R10] User picks burst; strap picks two or unlimited
// [R11] Slave time-out aborts cycle, flags nonexistent memory
// [R12] Three time-outs selectable, 12 and 33 included
// [R13] Burst release timer restarts each word
// [R14] Straps static inputs; limits are parameters
module diso_strap_dma
	import diso_pkg::*;
#(
	parameter int TMO_SHORT_CYC = `DISO_TMO_SHORT_CYC,
	parameter int TMO_MID_CYC   = `DISO_TMO_MID_CYC,
	parameter int TMO_LONG_CYC  = `DISO_TMO_LONG_CYC,
	parameter int BRT_CYC       = `DISO_BRT_CYC
) (
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic [2:0]         regAddr,
	input  wire diso_pkg::diso_word_t regWdata,
	input  wire logic               regWr,
	input  wire logic               regRd,
	output diso_pkg::diso_word_t    regRdata,
	input  wire diso_pkg::diso_busy_e strapBusyMode,
	input  wire logic               strapByteSuppress,
	input  wire logic               strapErrInfoHide,
	input  wire logic               strapBurstUnlimited,
	input  wire diso_pkg::diso_tmo_e strapTimeoutSel,
	input  wire logic               userWordReady,
	input  wire logic               userBurstReq,
	input  wire logic               byteSelectInput,
	input  wire logic               farReady,
	output logic                    userWordTaken,
	output logic                    busyOut,
	output logic                    busRequest,
	input  wire logic               busGrant,
	output logic                    busMaster,
	output logic                    busCycle,
	output logic [17:0]             busAddr,
	input  wire logic               slaveAck,
	output logic                    irq
);
	import diso_pkg::*;

	// All strap, user and bus pins through the three-stage synchroniser
	localparam int NSYNC = 13;
	logic [NSYNC-1:0] pinVec;
	logic [NSYNC-1:0] pinSync;
	assign pinVec = {strapBusyMode, strapByteSuppress, strapErrInfoHide,
		strapBurstUnlimited, strapTimeoutSel, userWordReady, userBurstReq,
		byteSelectInput, farReady, busGrant, slaveAck};

	diso_sync3 #(.WIDTH(NSYNC)) diso_sync3_inst (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pinIn   (pinVec),
		.syncOut (pinSync)
	);

	diso_busy_e busyModeS;
	diso_tmo_e  tmoSelS;
	logic       suppS;
	logic       hideS;
	logic       burstNS;
	logic       readyS;
	logic       burstReqS;
	logic       byteSelS;
	logic       farReadyS;
	logic       grantS;
	logic       ackS;
	assign busyModeS = diso_busy_e'(pinSync[12:11]);
	assign suppS     = pinSync[10];
	assign hideS     = pinSync[9];
	assign burstNS   = pinSync[8];
	assign tmoSelS   = diso_tmo_e'(pinSync[7:6]);
	assign readyS    = pinSync[5];
	assign burstReqS = pinSync[4];
	assign byteSelS  = pinSync[3];
	assign farReadyS = pinSync[2];
	assign grantS    = pinSync[1];
	assign ackS      = pinSync[0];

	diso_state_e state_r;
	diso_state_e state_nxt;
	logic        go_r;
	logic [15:0] wcnt_r;
	logic [17:0] bar_r;
	logic [2:0]  stat_r;
	logic [2:0]  mask_r;
	logic [15:0] errInfo_r;
	logic [15:0] tmr_r;
	logic        firstDone_r;
	logic        wordPend_r;

	// Slave time-out limit by strap; unused code falls to the longest
	logic [15:0] tmoLimit;
	always_comb begin
		unique case (tmoSelS)
			DISO_TMO_SHORT: tmoLimit = 16'(TMO_SHORT_CYC); // [R12]
			DISO_TMO_MID:   tmoLimit = 16'(TMO_MID_CYC); // [R12]
			default:        tmoLimit = 16'(TMO_LONG_CYC); // [R14]
		endcase
	end

	// Register decode
	wire wrCtrl  = regWr && regAddr == `DISO_REG_CTRL;
	wire wrWcnt  = regWr && regAddr == `DISO_REG_WCNT;
	wire wrBar   = regWr && regAddr == `DISO_REG_BAR;
	wire wrStat  = regWr && regAddr == `DISO_REG_STAT;
	wire wrMask  = regWr && regAddr == `DISO_REG_MASK;

	// Transfer events
	wire startOk    = readyS && !wordPend_r && !ackS;
	wire wordDone   = state_r == DISO_XFER && ackS;
	wire slaveTmo   = state_r == DISO_XFER && !ackS && tmr_r >= tmoLimit;
	wire brtExpire  = state_r == DISO_GAP && !startOk &&
		tmr_r >= 16'(BRT_CYC);
	wire lastWord   = wcnt_r == 16'h0001;
	// One word without burst request, two in two-cycle mode
	wire burstLimit = !burstReqS || (!burstNS && firstDone_r); // [R9] [R10]
	wire doneEvt    = wordDone && lastWord;
	wire [2:0] evtSet = {brtExpire, slaveTmo, doneEvt};

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			DISO_IDLE: begin
				if (go_r && startOk) begin
					state_nxt = DISO_REQ;
				end
			end
			DISO_REQ: begin
				if (grantS) begin
					state_nxt = DISO_XFER;
				end
			end
			DISO_XFER: begin
				if (wordDone) begin
					if (lastWord || burstLimit) begin // [R9]
						state_nxt = DISO_RELEASE;
					end else begin
						state_nxt = DISO_GAP;
					end
				end else if (slaveTmo) begin
					state_nxt = DISO_RELEASE; // [R11]
				end
			end
			DISO_GAP: begin
				if (startOk) begin
					state_nxt = DISO_XFER;
				end else if (brtExpire) begin
					state_nxt = DISO_RELEASE; // [R13]
				end
			end
			DISO_RELEASE: state_nxt = DISO_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= DISO_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Timer restarts on every new cycle or word
	always_ff @(posedge clk) begin
		if (sys_rst || state_r != state_nxt) begin
			tmr_r <= 16'h0000; // [R13]
		end else if (tmr_r != 16'hFFFF) begin
			tmr_r <= tmr_r + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || state_r == DISO_RELEASE) begin
			firstDone_r <= 1'b0;
		end else if (wordDone) begin
			firstDone_r <= 1'b1;
		end
	end

	// Stale ready must drop before the next word is accepted
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wordPend_r <= 1'b0;
		end else if (wordDone) begin
			wordPend_r <= 1'b1;
		end else if (!readyS) begin
			wordPend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			go_r <= 1'b0;
		end else if (doneEvt || slaveTmo) begin
			go_r <= 1'b0; // [R11]
		end else if (wrCtrl) begin
			go_r <= regWdata[`DISO_CTRL_GO];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wcnt_r <= `DISO_RST_WORD;
		end else if (wrWcnt) begin
			wcnt_r <= regWdata;
		end else if (wordDone) begin
			wcnt_r <= wcnt_r - 16'h0001;
		end
	end

	// Word addressing: the engine itself never steps by bytes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bar_r <= `DISO_RST_ADDR;
		end else if (wrBar) begin
			bar_r <= {2'b00, regWdata[15:1], 1'b0};
		end else if (wordDone) begin
			bar_r <= bar_r + 18'h00002; // [R3]
		end
	end

	// Latched failing address, low 16 bits
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			errInfo_r <= `DISO_RST_WORD;
		end else if (slaveTmo) begin
			errInfo_r <= bar_r[15:0]; // [R11]
		end
	end

	// Sticky events; a new event wins over a write-one clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stat_r <= `DISO_RST_EVT;
		end else begin
			stat_r <= (stat_r & ~({3{wrStat}} & regWdata[2:0])) | evtSet;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mask_r <= `DISO_RST_EVT;
		end else if (wrMask) begin
			mask_r <= regWdata[2:0];
		end
	end

	// Byte select comes from the user unless suppressed
	wire addrBit0 = suppS ? 1'b0 : byteSelS; // [R4] [R5]
	// Linked pair: far end readiness appears in bit zero unless suppressed
	wire barBit0  = suppS ? 1'b0 : farReadyS; // [R6]

	// Busy polarity and timing by strap; pairs rely on the low setting
	logic busyNxt;
	always_comb begin
		unique case (busyModeS)
			DISO_BUSY_HIGH:         busyNxt = go_r; // [R1]
			DISO_BUSY_LOW:          busyNxt = !go_r; // [R1] [R2]
			DISO_BUSY_LEGACY_TIMED: busyNxt = state_r != DISO_XFER; // [R1]
			default:                busyNxt = go_r;
		endcase
	end

	// Read mux; the hidden register reads as unmapped
	logic [15:0] rdMux;
	always_comb begin
		rdMux = 16'h0000;
		unique case (regAddr)
			`DISO_REG_CTRL: rdMux = {13'h0000, state_r == DISO_XFER,
				state_r != DISO_IDLE, go_r};
			`DISO_REG_WCNT: rdMux = wcnt_r;
			`DISO_REG_BAR:  rdMux = {bar_r[15:1], barBit0};
			`DISO_REG_STAT: rdMux = {13'h0000, stat_r};
			`DISO_REG_MASK: rdMux = {13'h0000, mask_r};
			`DISO_REG_ERRINFO: rdMux = hideS ? 16'h0000 : errInfo_r; // [R7]
			default:        rdMux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regRdata      <= `DISO_RST_WORD;
			busyOut       <= 1'b0;
			busRequest    <= 1'b0;
			busMaster     <= 1'b0;
			busCycle      <= 1'b0;
			busAddr       <= `DISO_RST_ADDR;
			userWordTaken <= 1'b0;
			irq           <= 1'b0;
		end else begin
			regRdata      <= regRd ? rdMux : 16'h0000;
			busyOut       <= busyNxt;
			busRequest    <= state_nxt == DISO_REQ;
			busMaster     <= state_nxt == DISO_XFER || state_nxt == DISO_GAP;
			busCycle      <= state_nxt == DISO_XFER;
			busAddr       <= {bar_r[17:1], addrBit0};
			userWordTaken <= wordDone;
			irq           <= |(stat_r & mask_r);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_addr_forced: assert property ($past(suppS) |-> !busAddr[0]) // [R5]
		else $error("address bit zero not forced low");
	a_addr_follow: assert property (
		!$past(suppS) |-> busAddr[0] == $past(byteSelS)) // [R4]
		else $error("address bit zero does not follow input");
	a_bar_far_ready: assert property (
		regRd && regAddr == `DISO_REG_BAR
		|=> regRdata[0] == ($past(farReadyS) && !$past(suppS))) // [R6]
		else $error("bar bit zero not showing far ready");
	a_errinfo_hidden: assert property (
		regRd && regAddr == `DISO_REG_ERRINFO && hideS
		|=> regRdata == 16'h0000) // [R7]
		else $error("error info register visible while hidden");
	a_one_word: assert property (
		wordDone && !burstReqS |=> state_r == DISO_RELEASE ##1 !busMaster) // [R9]
		else $error("non-burst mastership moved more than one word");
	a_two_word: assert property (
		wordDone && !burstNS && firstDone_r |=> state_r == DISO_RELEASE) // [R9]
		else $error("two-cycle burst exceeded two words");
	a_slave_tmo: assert property (
		slaveTmo |=> stat_r[`DISO_STAT_NXM] && !go_r
		##1 !busCycle) // [R11]
		else $error("slave time-out did not abort the cycle");
	a_tmo_bound: assert property (
		state_r == DISO_XFER |-> tmr_r <= tmoLimit) // [R12]
		else $error("cycle outlived the selected time-out");
	a_burst_release: assert property (
		brtExpire |=> state_r == DISO_RELEASE ##1 !busMaster) // [R13]
		else $error("burst release timer did not free the bus");
	a_busy_low: assert property (
		busyModeS == DISO_BUSY_LOW && $stable(busyModeS)
		|=> busyOut == !$past(go_r)) // [R1]
		else $error("low busy polarity wrong");
	a_irq_level: assert property (
		##1 irq == |($past(stat_r) & $past(mask_r)))
		else $error("interrupt level mismatch");

	c_nxm: cover property (slaveTmo);
	c_burst_release: cover property (brtExpire);
	c_long_burst: cover property (wordDone && burstNS && firstDone_r
		&& !lastWord);
	c_done: cover property (doneEvt);
endmodule

//--- diso_bus_partner.sv
// Host bus slave, arbiter and user word source facing the DMA block
`timescale 1ns/1ps
module diso_bus_partner (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       noAck,
	input  wire logic       userOn,
	input  wire logic [7:0] stall,
	input  wire logic       busRequest,
	input  wire logic       busMaster,
	input  wire logic       busCycle,
	input  wire logic       userWordTaken,
	output logic            busGrant,
	output logic            slaveAck,
	output logic            userWordReady
);
	logic [7:0] gap;
	logic [1:0] ackDly;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busGrant      <= 1'b0;
			slaveAck      <= 1'b0;
			userWordReady <= 1'b0;
			gap           <= 8'h00;
			ackDly        <= 2'h0;
		end else begin
			busGrant <= busRequest | (busGrant & busMaster);
			if (!busCycle)
				ackDly <= 2'h0;
			else if (ackDly != 2'h3)
				ackDly <= ackDly + 2'h1;
			// Silent slave lets the master's time-out fire
			slaveAck <= busCycle & (ackDly == 2'h3) & !noAck;
			// Ready must fall after each taken word
			if (userWordTaken) begin
				userWordReady <= 1'b0;
				gap           <= stall;
			end else if (gap != 8'h00)
				gap <= gap - 8'h01;
			else
				userWordReady <= userOn;
		end
	end
endmodule

//--- dma_interface_strap_options_tb.sv
// Self-checking bench for the strap-option DMA block
`timescale 1ns/1ps
`include "diso_consts.svh"
module dma_interface_strap_options_tb;
	import diso_pkg::*;
	localparam int TS = 20;
	localparam int TM = 40;
	localparam int TL = 60;
	localparam int BR = 20;
	logic        clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
	logic [2:0]  regAddr = 3'h0;
	diso_word_t  regWdata = 16'h0000, regRdata;
	diso_busy_e  busyMode = DISO_BUSY_LOW;
	diso_tmo_e   tmoSel = DISO_TMO_SHORT;
	logic        byteSup = 1'b0, errHide = 1'b0, burstUnl = 1'b0;
	logic        burstReq = 1'b0, byteSel = 1'b0, farReady = 1'b0;
	logic        noAck = 1'b0, userOn = 1'b1, mPrev = 1'b0, addrLow = 1'b0;
	logic [7:0]  stall = 8'h02;
	logic        wordReady, wordTaken, busyOut, busRequest, busGrant;
	logic        busMaster, busCycle, slaveAck, irq;
	logic [17:0] busAddr;
	logic [17:0] addrSeen = 18'h00000;
	int          errors = 0, tests_run = 0, masters = 0, cycLen = 0;
	int          takes = 0;

	always #2.5 clk = ~clk;

	diso_strap_dma #(.TMO_SHORT_CYC(TS), .TMO_MID_CYC(TM),
		.TMO_LONG_CYC(TL), .BRT_CYC(BR)) diso_strap_dma_inst (
		.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .strapBusyMode(busyMode),
		.strapByteSuppress(byteSup), .strapErrInfoHide(errHide),
		.strapBurstUnlimited(burstUnl), .strapTimeoutSel(tmoSel),
		.userWordReady(wordReady), .userBurstReq(burstReq),
		.byteSelectInput(byteSel), .farReady(farReady),
		.userWordTaken(wordTaken), .busyOut(busyOut),
		.busRequest(busRequest), .busGrant(busGrant),
		.busMaster(busMaster), .busCycle(busCycle), .busAddr(busAddr),
		.slaveAck(slaveAck), .irq(irq));

	diso_bus_partner diso_bus_partner_inst (
		.clk(clk), .sys_rst(sys_rst), .noAck(noAck), .userOn(userOn),
		.stall(stall), .busRequest(busRequest), .busMaster(busMaster),
		.busCycle(busCycle), .userWordTaken(wordTaken),
		.busGrant(busGrant), .slaveAck(slaveAck),
		.userWordReady(wordReady));

	// Masterships, cycle length and address bit seen on the host bus
	always @(posedge clk) begin
		mPrev <= busMaster;
		if (busMaster && !mPrev)
			masters <= masters + 1;
		if (busCycle)
			cycLen <= cycLen + 1;
		else if (busRequest)
			cycLen <= 0;
		if (busCycle)
			addrLow <= busAddr[0];
		if (busCycle)
			addrSeen <= busAddr;
		if (wordTaken)
			takes <= takes + 1;
	end

	task automatic check(input string what, input logic [17:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [2:0] a, input diso_word_t d);
		@(posedge clk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output diso_word_t d);
		@(posedge clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		// Data stand only in the cycle after the strobe edge
		@(posedge clk);
		d = regRdata;
	endtask

	task automatic rdc(input string w, input logic [2:0] a, diso_word_t e);
		diso_word_t d;
		rd(a, d);
		check(w, {2'h0, d}, {2'h0, e});
	endtask

	task automatic clr();
		wr(`DISO_REG_STAT, 16'h0007);
		rdc("stat clear", `DISO_REG_STAT, 16'h0000);
		check("irq clear", {17'h0, irq}, 18'h0);
	endtask

	task automatic run(input diso_word_t n);
		diso_word_t d;
		masters = 0;
		takes   = 0;
		wr(`DISO_REG_WCNT, n);
		wr(`DISO_REG_BAR, 16'h0100);
		wr(`DISO_REG_CTRL, 16'h0001);
		repeat (4) @(posedge clk);
		check("busy go", {17'h0, busyOut}, 18'h0);
		d = 16'h0000;
		for (int k = 0; k < 500 && d[1:0] == 2'h0; k++)
			rd(`DISO_REG_STAT, d);
		check("finished", {17'h0, |d[1:0]}, 18'h1);
		check("irq", {17'h0, irq}, 18'h1);
	endtask

	task automatic t_regs();
		rdc("wcnt", `DISO_REG_WCNT, 16'h0000);
		rdc("unmapped", 3'h6, 16'h0000);
		wr(3'h7, 16'hFFFF);
		rdc("unmapped wr", 3'h7, 16'h0000);
		wr(`DISO_REG_BAR, 16'h1235);
		rdc("bar", `DISO_REG_BAR, 16'h1234);
		farReady <= 1'b1;
		repeat (8) @(posedge clk);
		rdc("bar far", `DISO_REG_BAR, 16'h1235);
		byteSup <= 1'b1;
		repeat (8) @(posedge clk);
		rdc("bar sup", `DISO_REG_BAR, 16'h1234);
		byteSup  <= 1'b0;
		farReady <= 1'b0;
		$display("Test regs done");
	endtask

	task automatic t_busy();
		logic e;
		// Code three is unused and must act as high
		for (int i = 0; i < 4; i++) begin
			busyMode <= diso_busy_e'(i);
			e = (i == 1 || i == 2);
			repeat (8) @(posedge clk);
			check("busy idle", {17'h0, busyOut}, {17'h0, e});
		end
		busyMode <= DISO_BUSY_LOW;
		repeat (8) @(posedge clk);
		$display("Test busy done");
	endtask

	task automatic t_modes();
		byteSel <= 1'b1;
		run(16'h0003);
		check("one word", masters[17:0], 18'h3);
		check("taken", takes[17:0], 18'h3);
		check("byte bit", {17'h0, addrLow}, 18'h1);
		check("bus addr", addrSeen, 18'h00105);
		rdc("bar step", `DISO_REG_BAR, 16'h0106);
		rdc("wcnt end", `DISO_REG_WCNT, 16'h0000);
		clr();
		byteSup  <= 1'b1;
		burstReq <= 1'b1;
		run(16'h0004);
		check("two burst", masters[17:0], 18'h2);
		check("byte forced", {17'h0, addrLow}, 18'h0);
		clr();
		burstUnl <= 1'b1;
		run(16'h0004);
		check("n burst", masters[17:0], 18'h1);
		clr();
		// Stall longer than the release timer
		stall <= 8'h28;
		run(16'h0002);
		check("release", masters[17:0], 18'h2);
		check("release takes", takes[17:0], 18'h2);
		rdc("release flag", `DISO_REG_STAT, 16'h0005);
		clr();
		stall    <= 8'h02;
		burstReq <= 1'b0;
		$display("Test modes done");
	endtask

	task automatic t_nxm();
		int         lim [4] = '{TS, TM, TL, TL};
		logic       ok;
		diso_word_t ei;
		noAck <= 1'b1;
		// Code three is unused and must act as the longest
		for (int i = 0; i < 4; i++) begin
			tmoSel  <= diso_tmo_e'(i);
			errHide <= (i >= 2);
			ei      = (i >= 2) ? 16'h0000 : 16'h0100;
			repeat (8) @(posedge clk);
			run(16'h0001);
			ok = cycLen >= lim[i] && cycLen <= lim[i] + 8;
			check("timeout", {17'h0, ok}, 18'h1);
			rdc("nxm flag", `DISO_REG_STAT, 16'h0002);
			rdc("errinfo", `DISO_REG_ERRINFO, ei);
			clr();
		end
		noAck <= 1'b0;
		$display("Test timeout done");
	endtask

	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (5) @(posedge clk);
		wr(`DISO_REG_MASK, 16'h0007);
		t_regs();
		t_busy();
		t_modes();
		t_nxm();
		give_verdict();
	end

	// Whole run needs well under this many cycles
	initial begin
		#(5 * 40000);
		errors++;
		give_verdict();
	end
endmodule
